/* verilog/cimp_pins.sv */
// module-side pin mux: memory-only card before configuration,
// command port plus transport stream buses afterwards
// assumes host strobes are slow against clk_in; all pins are synchronised
`timescale 1ns/1ps
module cimp_pins (
   // clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // host control pins
   input wire logic ce1_n_in,
   input wire logic ce2_n_in,
   input wire logic oe_n_in,
   input wire logic we_n_in,
   input wire logic iord_n_in,
   input wire logic iowr_n_in,
   input wire logic reg_n_in,
   // host address and data pins
   input wire logic [cimp_pkg::ADDR_W-1:0] addr_in,
   input wire logic [cimp_pkg::DATA_W-1:0] data_in,
   output logic [cimp_pkg::DATA_W-1:0] data_out,
   output logic [cimp_pkg::DATA_W-1:0] data_oe_n_out,
   // status pins
   output logic bvd1_out,
   output logic bvd1_oe_n_out,
   output logic bvd2_out,
   output logic bvd2_oe_n_out,
   output logic vs2_out,
   output logic vs2_oe_n_out,
   output logic iois16_n_out,
   // card logic: mode
   input wire logic config_set_in,
   output logic configured_out,
   // card logic: command interface
   output logic [cimp_pkg::CMD_ADDR_W-1:0] cmd_addr_out,
   output logic [cimp_pkg::BYTE_W-1:0] cmd_wdata_out,
   output logic cmd_wr_out,
   output logic cmd_rd_out,
   input wire logic [cimp_pkg::BYTE_W-1:0] cmd_rdata_in,
   // card logic: transport stream buses
   output logic [cimp_pkg::TS_IN_W-1:0] ts_in_out,
   input wire logic [cimp_pkg::TS_OUT_W-1:0] ts_out_in
);
   // byte index into attribute memory, upper lines never looked at
   function automatic logic [cimp_pkg::ATTR_IDX_W-1:0] attr_idx(
      input logic [cimp_pkg::PIN_W-1:0] p
   );
      attr_idx = p[cimp_pkg::P_ADDR+1 +: cimp_pkg::ATTR_IDX_W];
   endfunction

   // low data byte of a sampled pin vector
   function automatic logic [cimp_pkg::BYTE_W-1:0] lo_byte(
      input logic [cimp_pkg::PIN_W-1:0] p
   );
      lo_byte = p[cimp_pkg::P_DATA +: cimp_pkg::BYTE_W];
   endfunction

   cimp_mem_if mem_bus ();

   cimp_attr_mem u_attr_mem (
      .clk_in(clk_in),
      .port(mem_bus.mem)
   );

   logic [cimp_pkg::PIN_W-1:0] raw;
   logic [cimp_pkg::PIN_W-1:0] sync1_r, sync1_nxt;
   logic [cimp_pkg::PIN_W-1:0] sync2_r, sync2_nxt;
   logic [cimp_pkg::PIN_W-1:0] prev_r, prev_nxt;
   cimp_pkg::cimp_mode_e mode_r, mode_nxt;
   logic [cimp_pkg::DATA_W-1:0] data_r, data_nxt;
   logic [cimp_pkg::DATA_W-1:0] doe_n_r, doe_n_nxt;
   logic bvd1_r, bvd1_nxt, bvd2_r, bvd2_nxt, vs2_r, vs2_nxt;
   logic bvd_oe_n_r, bvd_oe_n_nxt, vs2_oe_n_r, vs2_oe_n_nxt;
   logic [cimp_pkg::CMD_ADDR_W-1:0] cmd_addr_r, cmd_addr_nxt;
   logic [cimp_pkg::BYTE_W-1:0] cmd_wdata_r, cmd_wdata_nxt;
   logic cmd_wr_r, cmd_wr_nxt, cmd_rd_r, cmd_rd_nxt;
   logic [cimp_pkg::TS_IN_W-1:0] ts_in_r, ts_in_nxt;
   logic cfg, sel, attr_rd, attr_wr, io_rd, io_rd_start, io_wr;

   // ce2 rides along in the vector but no decode ever reads it
   assign raw = {data_in, addr_in, reg_n_in, iowr_n_in, iord_n_in,
                 we_n_in, oe_n_in, ce2_n_in, ce1_n_in};

   // pin synchronisers and previous sample for strobe edges
   always_comb begin
      sync1_nxt = raw;
      sync2_nxt = sync1_r;
      prev_nxt = sync2_r;
   end

   // cycle decode on synchronised pins only
   always_comb begin
      cfg = (mode_r == cimp_pkg::CIMP_CONFIGURED);
      // only ce1 selects; ce2 is treated as high in both modes
      sel = !sync2_r[cimp_pkg::P_CE1] && !sync2_r[cimp_pkg::P_REG];
      // attribute read needs an even address, odd ones float
      attr_rd = sel && !sync2_r[cimp_pkg::P_OE]
                && !sync2_r[cimp_pkg::P_ADDR];
      // write taken at we rising edge, with address held from before it
      attr_wr = !prev_r[cimp_pkg::P_CE1] && !prev_r[cimp_pkg::P_REG]
                && !prev_r[cimp_pkg::P_WE] && sync2_r[cimp_pkg::P_WE]
                && !prev_r[cimp_pkg::P_ADDR];
      // i/o cycles exist only once configured; memory-only before
      io_rd = cfg && sel && !sync2_r[cimp_pkg::P_IORD];
      io_rd_start = io_rd && prev_r[cimp_pkg::P_IORD];
      io_wr = cfg && !prev_r[cimp_pkg::P_CE1] && !prev_r[cimp_pkg::P_REG]
              && !prev_r[cimp_pkg::P_IOWR]
              && sync2_r[cimp_pkg::P_IOWR];
   end

   // attribute memory port: write address from the held sample
   always_comb begin
      mem_bus.we = attr_wr;
      mem_bus.addr = attr_wr ? attr_idx(prev_r) : attr_idx(sync2_r);
      mem_bus.wdata = lo_byte(prev_r);
   end

   // mode: reset gives the memory-card assignment, card logic configures
   always_comb begin
      mode_nxt = mode_r;
      if (config_set_in) begin
         mode_nxt = cimp_pkg::CIMP_CONFIGURED;
      end
      if (sys_rst_in) begin
         mode_nxt = cimp_pkg::CIMP_MEM_ONLY;
      end
   end

   // data pins: low byte for reads, upper byte only for stream output
   always_comb begin
      data_nxt = data_r;
      doe_n_nxt = {cimp_pkg::DATA_W{cimp_pkg::OE_OFF}};
      // read data lags the strobe by a few clocks; host strobes are slow
      if (attr_rd) begin
         data_nxt[cimp_pkg::BYTE_W-1:0] = mem_bus.rdata;
      end else if (io_rd) begin
         data_nxt[cimp_pkg::BYTE_W-1:0] = cmd_rdata_in;
      end
      if (attr_rd || io_rd) begin
         doe_n_nxt[cimp_pkg::BYTE_W-1:0] =
            {cimp_pkg::BYTE_W{cimp_pkg::OE_ON}};
      end
      // unconfigured: the upper byte is never driven
      if (cfg) begin
         data_nxt[cimp_pkg::DATA_W-1:cimp_pkg::BYTE_W] =
            ts_out_in[cimp_pkg::BYTE_W-1:0];
         doe_n_nxt[cimp_pkg::DATA_W-1:cimp_pkg::BYTE_W] =
            {cimp_pkg::BYTE_W{cimp_pkg::OE_ON}};
      end
      if (sys_rst_in) begin
         data_nxt = {cimp_pkg::BYTE_ZERO, cimp_pkg::BYTE_ZERO};
         doe_n_nxt = {cimp_pkg::DATA_W{cimp_pkg::OE_OFF}};
      end
   end

   // status pins: bvd high before configuration, stream bits after
   always_comb begin
      bvd1_nxt = cimp_pkg::BVD_HIGH;
      bvd2_nxt = cimp_pkg::BVD_HIGH;
      vs2_nxt = cimp_pkg::PIN_IDLE;
      bvd_oe_n_nxt = cimp_pkg::OE_ON;
      vs2_oe_n_nxt = cimp_pkg::OE_OFF;
      if (cfg && !sys_rst_in) begin
         bvd1_nxt = ts_out_in[cimp_pkg::TS_BVD1];
         bvd2_nxt = ts_out_in[cimp_pkg::TS_BVD2];
         vs2_nxt = ts_out_in[cimp_pkg::TS_VS2];
         vs2_oe_n_nxt = cimp_pkg::OE_ON;
      end
   end

   // command port toward card logic and stream input capture
   always_comb begin
      cmd_addr_nxt = cmd_addr_r;
      cmd_wdata_nxt = cmd_wdata_r;
      cmd_wr_nxt = 1'b0;
      cmd_rd_nxt = 1'b0;
      ts_in_nxt = cfg ? sync2_r[cimp_pkg::P_ADDR+cimp_pkg::A_TS +:
                                cimp_pkg::TS_IN_W] : cimp_pkg::TS_ZERO;
      if (io_wr) begin
         cmd_addr_nxt = prev_r[cimp_pkg::P_ADDR +: cimp_pkg::A_LO_W];
         cmd_wdata_nxt = lo_byte(prev_r);
         cmd_wr_nxt = 1'b1;
      end else if (io_rd_start) begin
         cmd_addr_nxt = sync2_r[cimp_pkg::P_ADDR +: cimp_pkg::A_LO_W];
         cmd_rd_nxt = 1'b1;
      end
      if (sys_rst_in) begin
         cmd_addr_nxt = cimp_pkg::CMD_ZERO;
         cmd_wdata_nxt = cimp_pkg::BYTE_ZERO;
         cmd_wr_nxt = 1'b0;
         cmd_rd_nxt = 1'b0;
         ts_in_nxt = cimp_pkg::TS_ZERO;
      end
   end

   // state registers; reset is folded into the next values above, except the three pin sample stages, which reset here
   always_ff @(posedge clk_in) begin
      sync1_r <= sys_rst_in ? cimp_pkg::PINS_IDLE : sync1_nxt;
      sync2_r <= sys_rst_in ? cimp_pkg::PINS_IDLE : sync2_nxt;
      prev_r <= sys_rst_in ? cimp_pkg::PINS_IDLE : prev_nxt;
      mode_r <= mode_nxt;
      data_r <= data_nxt;
      doe_n_r <= doe_n_nxt;
      bvd1_r <= bvd1_nxt;
      bvd2_r <= bvd2_nxt;
      vs2_r <= vs2_nxt;
      bvd_oe_n_r <= bvd_oe_n_nxt;
      vs2_oe_n_r <= vs2_oe_n_nxt;
      cmd_addr_r <= cmd_addr_nxt;
      cmd_wdata_r <= cmd_wdata_nxt;
      cmd_wr_r <= cmd_wr_nxt;
      cmd_rd_r <= cmd_rd_nxt;
      ts_in_r <= ts_in_nxt;
   end

   // outputs straight from flops; iois16 is a constant, never asserted
   assign data_out = data_r;
   assign data_oe_n_out = doe_n_r;
   assign bvd1_out = bvd1_r;
   assign bvd2_out = bvd2_r;
   assign bvd1_oe_n_out = bvd_oe_n_r;
   assign bvd2_oe_n_out = bvd_oe_n_r;
   assign vs2_out = vs2_r;
   assign vs2_oe_n_out = vs2_oe_n_r;
   assign iois16_n_out = cimp_pkg::IOIS16_OFF;
   assign configured_out = (mode_r == cimp_pkg::CIMP_CONFIGURED);
   assign cmd_addr_out = cmd_addr_r;
   assign cmd_wdata_out = cmd_wdata_r;
   assign cmd_wr_out = cmd_wr_r;
   assign cmd_rd_out = cmd_rd_r;
   assign ts_in_out = ts_in_r;
endmodule // cimp_pins

/* verilog/cimp_pkg.sv */
// constants, pin positions and modes of the module-side card pin mux
// assumes all host pins are sampled on clk_in by the top module
//
// Behaviour
// - Command bytes travel on D0-D7 only and are addressed by A0-A14.
// - Command accesses are I/O cycles, never memory cycles.
// - Until configured the module looks like a memory-only card.
// - While unconfigured the upper data byte D8-D15 is never driven.
// - While unconfigured no 16-bit transfers exist, only low-byte ones.
// - While unconfigured CE2# is ignored and taken as high.
// - While unconfigured A15-A25 are not decoded, giving 32768 locations.
// - Attribute memory answers at even addresses only, 16384 bytes.
// - While unconfigured BVD1 and BVD2 are driven high all the time.
// - After reset the memory-card pin assignment is used until configured.
// - Once configured A15-A25, D8-D15, BVD1, BVD2, VS2# carry the streams.
// - Once configured all other pins keep their I/O and memory function.
// - Once configured IOIS16# is never asserted and CE2# stays ignored.
package cimp_pkg;
   // widths
   localparam int ADDR_W = 26;
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;
   localparam int CMD_ADDR_W = 15;
   localparam int ATTR_IDX_W = 14;
   localparam int ATTR_DEPTH = 16384;
   localparam int TS_IN_W = 11;
   localparam int TS_OUT_W = 11;
   // positions inside the sampled pin vector
   localparam int P_CE1 = 0;
   localparam int P_CE2 = 1;
   localparam int P_OE = 2;
   localparam int P_WE = 3;
   localparam int P_IORD = 4;
   localparam int P_IOWR = 5;
   localparam int P_REG = 6;
   localparam int P_ADDR = 7;
   localparam int P_DATA = P_ADDR + ADDR_W;
   localparam int PIN_W = P_DATA + DATA_W;
   // address split: A0-A14 command space, A15-A25 stream input
   localparam int A_LO_W = 15;
   localparam int A_TS = 15;
   // stream output bits beyond the upper data byte
   localparam int TS_BVD1 = 8;
   localparam int TS_BVD2 = 9;
   localparam int TS_VS2 = 10;
   // reset and idle values
   localparam logic PIN_IDLE = 1'b1;
   localparam logic OE_OFF = 1'b1;
   localparam logic OE_ON = 1'b0;
   localparam logic BVD_HIGH = 1'b1;
   localparam logic IOIS16_OFF = 1'b1;
   localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
   localparam logic [ATTR_IDX_W-1:0] IDX_ZERO = 14'h0000;
   localparam logic [CMD_ADDR_W-1:0] CMD_ZERO = 15'h0000;
   localparam logic [TS_IN_W-1:0] TS_ZERO = 11'h000;
   localparam logic [PIN_W-1:0] PINS_IDLE = {PIN_W{1'b1}};

   // pin assignment mode
   typedef enum logic {
      CIMP_MEM_ONLY,
      CIMP_CONFIGURED
   } cimp_mode_e;
endpackage

/* verilog/cimp_mem_if.sv */
// port bundle between the pin mux and its attribute memory
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface cimp_mem_if;
   logic [cimp_pkg::ATTR_IDX_W-1:0] addr;
   logic [cimp_pkg::BYTE_W-1:0] wdata;
   logic we;
   logic [cimp_pkg::BYTE_W-1:0] rdata;

   modport user (output addr, output wdata, output we, input rdata);
   modport mem (input addr, input wdata, input we, output rdata);
endinterface

/* verilog/cimp_attr_mem.sv */
// byte-wide attribute memory, one location per even host address
// assumes the user holds addr steady; read data one cycle late
`timescale 1ns/1ps
module cimp_attr_mem (
   // clock
   input wire logic clk_in,
   // access port
   cimp_mem_if.mem port
);
   logic [cimp_pkg::BYTE_W-1:0] store [cimp_pkg::ATTR_DEPTH];
   logic [cimp_pkg::BYTE_W-1:0] rdata_r;

   // contents are not reset, like any ram
   always_ff @(posedge clk_in) begin
      if (port.we) begin
         store[port.addr] <= port.wdata;
      end
      rdata_r <= store[port.addr];
   end

   assign port.rdata = rdata_r;
endmodule // cimp_attr_mem

/* sim/cimp_props.sv */
// checker for the card pin mux, watching top ports only
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module cimp_props (
   // clock, reset, host pins and card logic inputs
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic ce1_n_in,
   input wire logic iord_n_in,
   input wire logic [cimp_pkg::ADDR_W-1:0] addr_in,
   input wire logic config_set_in,
   input wire logic [cimp_pkg::TS_OUT_W-1:0] ts_out_in,
   // pin and card logic outputs
   input wire logic [cimp_pkg::DATA_W-1:0] data_out,
   input wire logic [cimp_pkg::DATA_W-1:0] data_oe_n_out,
   input wire logic bvd1_out,
   input wire logic bvd2_out,
   input wire logic vs2_out,
   input wire logic iois16_n_out,
   input wire logic bvd1_oe_n_out,
   input wire logic bvd2_oe_n_out,
   input wire logic vs2_oe_n_out,
   input wire logic configured_out,
   input wire logic [cimp_pkg::CMD_ADDR_W-1:0] cmd_addr_out,
   input wire logic cmd_wr_out,
   input wire logic cmd_rd_out,
   input wire logic [cimp_pkg::TS_IN_W-1:0] ts_in_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   // memory-only card: upper byte floats, status high, no io
   a_upper_float: assert property (!configured_out |->
      &data_oe_n_out[15:8]) else $error("upper byte driven");
   a_bvd_high: assert property (!configured_out |->
      bvd1_out && bvd2_out) else $error("status not high");
   a_no_iois16: assert property (iois16_n_out)
      else $error("wide io flag asserted");
   a_io_ignored: assert property (!configured_out |->
      !cmd_rd_out && !cmd_wr_out) else $error("io cycle unconfigured");
   // drive starts only for an even address seen two samples back
   a_even_only: assert property ($fell(data_oe_n_out[0]) &&
      !configured_out |-> $past(addr_in[0], 2) == 1'b0)
      else $error("odd attribute address answered");
   a_cfg_set: assert property (config_set_in |=> configured_out)
      else $error("configuration not taken");
   a_cfg_hold: assert property (configured_out |=> configured_out)
      else $error("configuration lost");
   a_ts_out: assert property (configured_out &&
      $past(configured_out) |->
      {vs2_out, bvd2_out, bvd1_out, data_out[15:8]} == $past(ts_out_in)
      && data_oe_n_out[15:8] == 8'h00) else $error("stream output wrong");
   // stream input lags the pins by two sync stages plus the capture flop
   a_ts_in: assert property (configured_out &&
      $past(configured_out) |-> ts_in_out == $past(addr_in[25:15], 3))
      else $error("stream input wrong");
   // status pins always driven; vs2 released until configured
   a_bvd_driven: assert property (!bvd1_oe_n_out && !bvd2_oe_n_out)
      else $error("status pins released");
   a_vs2_float: assert property (!configured_out |-> vs2_oe_n_out)
      else $error("vs2 driven unconfigured");
   a_vs2_drive: assert property (configured_out &&
      $past(configured_out) |-> !vs2_oe_n_out) else $error("vs2 not driven");
   a_cmd_rd: assert property ($rose(cmd_rd_out) |->
      $past(iord_n_in, 2) == 1'b0 && $past(ce1_n_in, 2) == 1'b0 &&
      cmd_addr_out == $past(addr_in[14:0], 2) ##1 !cmd_rd_out)
      else $error("command read wrong");
endmodule // cimp_props

bind cimp_pins cimp_props cimp_props_i (.clk_in, .sys_rst_in, .ce1_n_in,
   .iord_n_in, .addr_in, .config_set_in, .ts_out_in, .data_out,
   .data_oe_n_out, .bvd1_out, .bvd2_out, .vs2_out, .iois16_n_out,
   .bvd1_oe_n_out, .bvd2_oe_n_out, .vs2_oe_n_out,
   .configured_out, .cmd_addr_out, .cmd_wr_out, .cmd_rd_out, .ts_in_out);

/* sim/cimp_host.sv */
// host socket model: drives card pins, samples the low data byte
// assumes the bench calls access one cycle at a time
`timescale 1ns/1ps
module cimp_host (
   // clock and card data pins
   input wire logic clk_in,
   input wire logic [15:0] data_in,
   input wire logic [15:0] data_oe_n_in,
   // host pins {reg, iowr, iord, we, oe, ce2, ce1}
   output logic [6:0] ctl_n_out = 7'h7f,
   output logic [25:0] addr_out = '0,
   output logic [15:0] wire_out,
   // sampled read
   output logic done_out = 1'b0,
   output logic [8:0] rd_out = '0
);
   logic [15:0] hd_r = '0;
   logic [15:0] lv_r = '0;
   logic drv_r = 1'b0;
   // floating bits show the inverse of their last level
   always_comb for (int i = 0; i < 16; i++)
      wire_out[i] = !data_oe_n_in[i] ? data_in[i] : drv_r ? hd_r[i] : ~lv_r[i];
   always @(posedge clk_in) lv_r <= wire_out;
   // byte on D0-D7 only; strobes held 6 clocks, setup and hold 3+
   task automatic access(input logic io, wr, rg, ce2,
         input logic [25:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      hd_r <= {8'h00, d};
      drv_r <= wr;
      repeat (3) @(posedge clk_in);
      ctl_n_out <= {rg, !(io && wr), !(io && !wr), !(!io && wr),
         !(!io && !wr), ce2, 1'b0};
      repeat (6) @(posedge clk_in);
      rd_out <= {&data_oe_n_in[7:0],
         wire_out[7:0] & ~{8{&data_oe_n_in[7:0]}}};
      done_out <= !wr;
      ctl_n_out <= 7'h7f;
      @(posedge clk_in);
      done_out <= 1'b0;
      repeat (3) @(posedge clk_in);
      drv_r <= 1'b0;
   endtask
endmodule // cimp_host

/* sim/cimp_pins_tb.sv */
// bench for the card pin mux: host model, queued expectations
// assumes the checker binds itself onto cimp_pins
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin n_fail++; \
   $display("Error %s exp %h got %h", n, e, s); end end
module cimp_pins_tb;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic config_set_in = 1'b0;
   logic [7:0] cmd_rdata_in = 8'h00;
   logic [10:0] ts_out_in = 11'h000;
   logic [6:0] ctl_n;
   logic [25:0] addr, a;
   logic [15:0] wire_d, data_out, data_oe_n_out;
   logic bvd1_out, bvd1_oe_n_out, bvd2_out, bvd2_oe_n_out, vs2_out;
   logic vs2_oe_n_out, iois16_n_out, configured_out, cmd_wr_out, cmd_rd_out;
   logic done;
   // bench's own view of the mode, never taken from the design
   logic cfg_m = 1'b0;
   logic [14:0] cmd_addr_out;
   logic [7:0] cmd_wdata_out, b;
   logic [10:0] ts_in_out;
   logic [8:0] rd_val;
   logic [31:0] seed = 32'hdb2c74b2;
   logic [31:0] r;
   logic [22:0] e;
   logic [22:0] cq[$];
   logic [8:0] rq[$];
   int checks = 0;
   int n_fail = 0;
   cimp_host cimp_host_i (.clk_in, .data_in(data_out),
      .data_oe_n_in(data_oe_n_out), .ctl_n_out(ctl_n), .addr_out(addr),
      .wire_out(wire_d), .done_out(done), .rd_out(rd_val));
   cimp_pins cimp_pins_i (.clk_in, .sys_rst_in, .ce1_n_in(ctl_n[0]),
      .ce2_n_in(ctl_n[1]), .oe_n_in(ctl_n[2]), .we_n_in(ctl_n[3]),
      .iord_n_in(ctl_n[4]), .iowr_n_in(ctl_n[5]), .reg_n_in(ctl_n[6]),
      .addr_in(addr), .data_in(wire_d), .data_out, .data_oe_n_out,
      .bvd1_out, .bvd1_oe_n_out, .bvd2_out, .bvd2_oe_n_out, .vs2_out,
      .vs2_oe_n_out, .iois16_n_out, .config_set_in, .configured_out,
      .cmd_addr_out, .cmd_wdata_out, .cmd_wr_out, .cmd_rd_out,
      .cmd_rdata_in, .ts_in_out, .ts_out_in);
   always #5 clk_in = ~clk_in;
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // note the expectation, then run the cycle; ce2 is random
   task automatic acc(input logic io, wr, rg, input logic [25:0] aa,
         input logic [7:0] d, input logic [8:0] x);
      if (!wr) rq.push_back(x);
      if (io && cfg_m) cq.push_back({aa[14:0], d});
      if (io && !wr) cmd_rdata_in <= d;
      ts_out_in <= seed[10:0];
      cimp_host_i.access(io, wr, rg, seed[7], aa, d);
   endtask
   task automatic finish_test();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // compare each result with the oldest note as it shows up
   always @(posedge clk_in) begin
      if (done === 1'b1) begin
         e = rq.pop_front();
         `CHK("low byte read", e[8:0], rd_val)
      end
      if (cmd_wr_out === 1'b1 || cmd_rd_out === 1'b1) begin
         e = cq.pop_front();
         `CHK("command addr", e[22:8], cmd_addr_out)
         if (cmd_wr_out === 1'b1)
            `CHK("command data", e[7:0], cmd_wdata_out)
      end
   end
   // main sequence
   initial begin
      repeat (8) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      @(posedge clk_in);
      `CHK("idle enables", 16'hffff, data_oe_n_out)
      `CHK("idle status", 3'b110, {bvd1_out, bvd2_out, configured_out})
      // upper address bits are not decoded, so reads alias
      for (int i = 0; i < 4; i++) begin
         r = rnd();
         a = {r[25:1], 1'b0};
         acc(0, 1, 0, a, r[31:24], 9'h000);
         acc(0, 0, 0, {~a[25:15], a[14:0]}, 8'h00, {1'b0, r[31:24]});
      end
      b = r[31:24];
      // odd, common memory and io accesses all go unanswered
      acc(0, 1, 0, a | 26'h1, ~b, 9'h000);
      acc(0, 0, 0, a | 26'h1, 8'h00, 9'h100);
      acc(0, 0, 1, a, 8'h00, 9'h100);
      acc(1, 0, 0, a, 8'h5a, 9'h100);
      acc(1, 1, 0, a, 8'h5a, 9'h000);
      acc(0, 0, 0, a, 8'h00, {1'b0, b});
      config_set_in <= 1'b1;
      cfg_m = 1'b1;
      @(posedge clk_in);
      config_set_in <= 1'b0;
      @(posedge clk_in);
      `CHK("configured", 1'b1, configured_out)
      // configured: command port plus stream buses
      for (int i = 0; i < 4; i++) begin
         r = rnd();
         acc(1, 1, 0, r[25:0], r[31:24], 9'h000);
         acc(1, 0, 0, ~r[25:0], r[7:0], {1'b0, r[7:0]});
      end
      acc(0, 0, 0, a, 8'h00, {1'b0, b});
      repeat (4) @(posedge clk_in);
      `CHK("pending notes", 0, rq.size() + cq.size())
      finish_test();
   end
   // hang guard
   initial begin
      repeat (20000) @(posedge clk_in);
      n_fail++;
      finish_test();
   end
endmodule // cimp_pins_tb
